// *** core/pps_pkg.sv ***
package pps_pkg;

   // register map
   localparam logic [7:0] POWER_STATUS_ADDR  = 8'h1E;
   localparam logic [7:0] POWER_STATUS_RESET = 8'h00;

   // field positions of power_status
   localparam int BIT_DEBUG_ATTACHED = 7;
   localparam int BIT_INIT_PENDING   = 6;
   localparam int BIT_SOURCING_HIGH  = 5;
   localparam int BIT_SOURCING_BUS   = 4;
   localparam int BIT_MONITOR_ON     = 3;
   localparam int BIT_BUS_DETECTED   = 2;
   localparam int BIT_CABLE_SUPPLY   = 1;
   localparam int BIT_CONSUMING      = 0;

   // analog comparator flags, in synchroniser order
   localparam int CMP_ABOVE_4V     = 0;
   localparam int CMP_BELOW_3V5    = 1;
   localparam int CMP_VCONN_CC1    = 2;
   localparam int CMP_VCONN_CC2    = 3;
   localparam int CMP_BELOW_SAFE0V = 4;
   localparam int CMP_WIDTH        = 5;

   // sink disconnect threshold width and its "all zeros" value
   localparam int             SINK_THR_W    = 10;
   localparam logic [9:0]     SINK_THR_ZERO = 10'h000;

   // discharge time limit: figure in us, cycle count derived from clock rate
   localparam int CLK_MHZ             = 100;
   localparam int T_SAFE0V_US         = 1000;
   localparam int DISCHARGE_LIMIT_CYC = T_SAFE0V_US * CLK_MHZ;

   // status register layout, msb first
   typedef struct packed {
      logic debug_accessory_attached;
      logic initialization_pending;
      logic sourcing_high_voltage;
      logic sourcing_bus_power;
      logic bus_power_monitor_on;
      logic bus_power_detected;
      logic cable_supply_detected;
      logic consuming_bus_power;
   } pps_status_t;

   // register read answer
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } pps_rd_t;

endpackage

// *** core/pps_power_status.sv ***
`timescale 1ns/1ps
// How it works
// - Debug accessory detection sets the debug-attached bit, no pin needed.
// - Initialization-pending bit always reads zero; hardware never sets it.
// - High-voltage bit reads one while sourcing above safe 5 V; monitor only.
// - Sourcing bit mirrors whether bus power sourcing is enabled; status only.
// - Monitor-on bit is one while presence detection runs, zero when off.
// - Detected bit sets above 4 V, clears below 3.5 V, hysteresis between.
// - Detected falling, threshold zero, auto discharge on: discharge to safe zero.
// - Cable-supply bit asserts when VCONN is above 2.4 V on CC1 or CC2.
// - Consuming bit is one while sinking bus power, zero when disconnected.
// - Power status sits at offset 0x1E, resets to 0x00, all read only.
// - Auto discharge not reaching safe zero in time latches a failure flag.
module pps_power_status #(
   parameter int DISCHARGE_LIMIT_CYC = pps_pkg::DISCHARGE_LIMIT_CYC
) (
   // clock and reset
   input  wire logic                          core_clk_i,
   input  wire logic                          sys_rst_i,
   // register port from the serial management engine
   input  wire logic                          reg_rd_i,
   input  wire logic                          reg_wr_i,
   input  wire logic [7:0]                    reg_addr_i,
   input  wire logic [7:0]                    reg_wdata_i,
   output pps_pkg::pps_rd_t                   reg_rd_o,
   // analog comparator pins, asynchronous
   input  wire logic                          vbus_above_4v_i,
   input  wire logic                          vbus_below_3v5_i,
   input  wire logic                          vconn_cc1_above_2v4_i,
   input  wire logic                          vconn_cc2_above_2v4_i,
   input  wire logic                          vbus_below_safe0v_i,
   // port control state, same clock
   input  wire logic                          debug_accessory_i,
   input  wire logic                          sourcing_high_voltage_i,
   input  wire logic                          sourcing_bus_power_i,
   input  wire logic                          bus_power_monitor_on_i,
   input  wire logic                          consuming_bus_power_i,
   input  wire logic [pps_pkg::SINK_THR_W-1:0] sink_disc_threshold_i,
   input  wire logic                          auto_discharge_en_i,
   input  wire logic                          auto_discharge_failed_clr_i,
   // discharge control and fault
   output logic                               discharge_en_o,
   output logic                               auto_discharge_failed_o
);

   typedef struct packed {
      pps_pkg::pps_status_t status;
      logic                 discharging;
      logic [31:0]          timer;
      logic                 failed;
      pps_pkg::pps_rd_t     rd;
   } pps_st_t;

   localparam logic [31:0] DIS_LIMIT = 32'(DISCHARGE_LIMIT_CYC);

   pps_st_t                        st_ff;
   pps_st_t                        nxt_st;
   logic [pps_pkg::CMP_WIDTH-1:0] cmp_s;
   logic                           auto_arm;
   logic                           nxt_present;

   // comparator outputs cross into the core clock domain
   pps_sync3 #(
      .W (pps_pkg::CMP_WIDTH)
   ) u_cmp_sync (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .async_i    ({vbus_below_safe0v_i, vconn_cc2_above_2v4_i,
                    vconn_cc1_above_2v4_i, vbus_below_3v5_i, vbus_above_4v_i}),
      .sync_o     (cmp_s)
   );

   // discharge arms only with an all-zero sink threshold
   assign auto_arm = (sink_disc_threshold_i == pps_pkg::SINK_THR_ZERO)
                   && auto_discharge_en_i;

   // hysteresis: low threshold wins, band between keeps the last answer
   always_comb begin
      nxt_present = st_ff.status.bus_power_detected;
      if (!bus_power_monitor_on_i) begin
         nxt_present = 1'b0;
      end else if (cmp_s[pps_pkg::CMP_BELOW_3V5]) begin
         nxt_present = 1'b0;
      end else if (cmp_s[pps_pkg::CMP_ABOVE_4V]) begin
         nxt_present = 1'b1;
      end
   end

   // next state; status fields follow hardware only, writes never reach them
   always_comb begin
      nxt_st = st_ff;
      nxt_st.status.debug_accessory_attached = debug_accessory_i;
      nxt_st.status.initialization_pending   = 1'b0;
      nxt_st.status.sourcing_high_voltage    = sourcing_high_voltage_i;
      nxt_st.status.sourcing_bus_power       = sourcing_bus_power_i;
      nxt_st.status.bus_power_monitor_on     = bus_power_monitor_on_i;
      // detected bit may be stale for about 1 ms after enable; software waits
      nxt_st.status.bus_power_detected       = nxt_present;
      nxt_st.status.cable_supply_detected    = cmp_s[pps_pkg::CMP_VCONN_CC1]
                                             | cmp_s[pps_pkg::CMP_VCONN_CC2];
      nxt_st.status.consuming_bus_power      = consuming_bus_power_i;

      // clear goes first so a timeout in the same cycle still sets the flag
      if (auto_discharge_failed_clr_i) begin
         nxt_st.failed = 1'b0;
      end

      // discharge: start on falling detect, stop at safe zero or on timeout
      if (st_ff.discharging) begin
         if (cmp_s[pps_pkg::CMP_BELOW_SAFE0V]) begin
            nxt_st.discharging = 1'b0;
         end else if (st_ff.timer == DIS_LIMIT - 32'h0000_0001) begin
            nxt_st.discharging = 1'b0;
            nxt_st.failed      = 1'b1;
         end else begin
            nxt_st.timer = st_ff.timer + 32'h0000_0001;
         end
      end
      if (st_ff.status.bus_power_detected && !nxt_present && auto_arm) begin
         nxt_st.discharging = 1'b1;
         nxt_st.timer       = 32'h0000_0000;
      end

      // register read; writes are accepted and dropped
      nxt_st.rd.valid = reg_rd_i;
      nxt_st.rd.data  = 8'h00;
      if (reg_rd_i && reg_addr_i == pps_pkg::POWER_STATUS_ADDR) begin
         nxt_st.rd.data = st_ff.status;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         st_ff        <= '0;
         st_ff.status <= pps_pkg::POWER_STATUS_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rd_o                = st_ff.rd;
   assign discharge_en_o          = st_ff.discharging;
   assign auto_discharge_failed_o = st_ff.failed;

   // checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   // write data feeds nothing but the write-drop cover below; the write strobe also feeds chk_write_quiet
   logic wr_unused;
   assign wr_unused = reg_wr_i & (|reg_wdata_i);

   // status bits: each input shows one cycle later, read path one more
   chk_debug_bit: assert property (
         debug_accessory_i ##1 (reg_rd_i && reg_addr_i == pps_pkg::POWER_STATUS_ADDR)
         |=> reg_rd_o.data[pps_pkg::BIT_DEBUG_ATTACHED])
      else $error("debug bit not reported");
   chk_init_zero: assert property (
         !reg_rd_o.data[pps_pkg::BIT_INIT_PENDING])
      else $error("init pending bit set");
   chk_high_volt: assert property (
         sourcing_high_voltage_i |=> st_ff.status.sourcing_high_voltage)
      else $error("high voltage bit missing");
   chk_sourcing_bit: assert property (
         !sourcing_bus_power_i |=> !st_ff.status.sourcing_bus_power)
      else $error("sourcing bit stuck");
   chk_monitor_off: assert property (
         !bus_power_monitor_on_i
         |=> !st_ff.status.bus_power_monitor_on && !st_ff.status.bus_power_detected)
      else $error("detect reported while monitor off");

   // presence hysteresis, judged on the synchronised comparators
   chk_detect_hyst: assert property (
         bus_power_monitor_on_i && cmp_s[pps_pkg::CMP_ABOVE_4V]
         && !cmp_s[pps_pkg::CMP_BELOW_3V5]
         |=> st_ff.status.bus_power_detected)
      else $error("detect not set above 4 V");
   chk_detect_drop: assert property (
         cmp_s[pps_pkg::CMP_BELOW_3V5] |=> !st_ff.status.bus_power_detected)
      else $error("detect kept below 3.5 V");
   chk_vconn_bit: assert property (
         cmp_s[pps_pkg::CMP_VCONN_CC2] |=> st_ff.status.cable_supply_detected)
      else $error("vconn on cc2 missed");
   chk_sink_bit: assert property (
         consuming_bus_power_i ##1 !consuming_bus_power_i
         |=> !st_ff.status.consuming_bus_power)
      else $error("sink bit stuck");

   // discharge start, end and the sticky failure flag
   chk_discharge_go: assert property (
         $fell(st_ff.status.bus_power_detected) && $past(auto_arm) |-> discharge_en_o)
      else $error("auto discharge not started");
   chk_discharge_end: assert property (
         discharge_en_o && cmp_s[pps_pkg::CMP_BELOW_SAFE0V] |=> !discharge_en_o)
      else $error("discharge ran past safe zero");
   chk_fail_cause: assert property (
         $rose(auto_discharge_failed_o) |-> $past(discharge_en_o) && !discharge_en_o)
      else $error("failure flag without discharge timeout");
   chk_fail_hold: assert property (
         auto_discharge_failed_o && !auto_discharge_failed_clr_i
         |=> auto_discharge_failed_o)
      else $error("failure flag dropped without clear");

   // register port: one answer per read, none per write
   chk_read_data: assert property (
         reg_rd_i && reg_addr_i == pps_pkg::POWER_STATUS_ADDR
         |=> reg_rd_o.valid && reg_rd_o.data == $past(st_ff.status))
      else $error("read data mismatch");
   chk_write_quiet: assert property (
         reg_wr_i && !reg_rd_i |=> !reg_rd_o.valid)
      else $error("write produced an answer");

   // main scenarios
   cov_discharge_ok: cover property (discharge_en_o ##1 !discharge_en_o
         && !auto_discharge_failed_o);
   cov_discharge_fail: cover property ($rose(auto_discharge_failed_o));
   cov_read_status: cover property (reg_rd_o.valid && reg_rd_o.data != 8'h00);
   cov_write_drop: cover property (wr_unused);
   cov_detect_rise: cover property ($rose(st_ff.status.bus_power_detected));

endmodule

// *** core/pps_sync3.sv ***
`timescale 1ns/1ps
// three-stage synchroniser; q follows only once stages two and three agree
module pps_sync3 #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         core_clk_i,
   input  wire logic         sys_rst_i,
   // asynchronous in, synchronous out
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } pps_sync_st_t;

   pps_sync_st_t st_ff;
   pps_sync_st_t nxt_st;

   // stage one feeds stage two only, to keep metastability contained
   always_comb begin
      nxt_st    = st_ff;
      nxt_st.s1 = async_i;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      for (int i = 0; i < W; i++) begin
         if (st_ff.s2[i] == st_ff.s3[i]) begin
            nxt_st.q[i] = st_ff.s3[i];
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sync_o = st_ff.q;

endmodule

// *** tb/pps_pm_model.sv ***
`timescale 1ns/1ps
// port manager side of the register port: one byte per strobe
module pps_pm_model (
   // clock
   input  wire logic        core_clk_i,
   // register port toward the block
   output logic             rd_o,
   output logic             wr_o,
   output logic [7:0]       addr_o,
   output logic [7:0]       wdata_o,
   input  pps_pkg::pps_rd_t rsp_i
);
   // idle port at time zero
   initial begin
      rd_o = 1'b0;
      wr_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 8'h00;
   end

   // read: strobe one cycle, then wait a bounded span for valid
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int n;
      @(posedge core_clk_i);
      #1;
      rd_o = 1'b1;
      addr_o = a;
      @(posedge core_clk_i);
      #1;
      rd_o = 1'b0;
      addr_o = ~a; // released address no longer shows the last value
      n = 0;
      while (rsp_i.valid !== 1'b1 && n < 3) begin
         @(posedge core_clk_i);
         #1;
         n++;
      end
      d = (rsp_i.valid === 1'b1) ? rsp_i.data : 8'hXX;
   endtask

   // write: strobe one cycle, no answer expected
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk_i);
      #1;
      wr_o = 1'b1;
      addr_o = a;
      wdata_o = v;
      @(posedge core_clk_i);
      #1;
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~v;
   endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
   logic core_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic rd, wr, dis, fail;
   logic [7:0] addr, wdata, d;
   pps_pkg::pps_rd_t rsp;
   logic a4 = 1'b0, b35 = 1'b0, c1 = 1'b0, c2 = 1'b0, s0 = 1'b0, aen = 1'b0, fclr = 1'b0;
   logic [4:0] ctl = 5'h00;
   logic [9:0] thr = 10'h000;
   logic [7:0] bitv [5] = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h01};
   int n_mismatch = 0;
   int num_checks = 0;
   int n;

   always #5 core_clk_i = ~core_clk_i;

   pps_pm_model pm (.core_clk_i(core_clk_i), .rd_o(rd), .wr_o(wr), .addr_o(addr),
      .wdata_o(wdata), .rsp_i(rsp));

   // short discharge limit keeps the timeout case quick
   pps_power_status #(.DISCHARGE_LIMIT_CYC(20)) dut (.core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i), .reg_rd_i(rd), .reg_wr_i(wr), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_rd_o(rsp), .vbus_above_4v_i(a4), .vbus_below_3v5_i(b35),
      .vconn_cc1_above_2v4_i(c1), .vconn_cc2_above_2v4_i(c2), .vbus_below_safe0v_i(s0),
      .debug_accessory_i(ctl[4]), .sourcing_high_voltage_i(ctl[3]),
      .sourcing_bus_power_i(ctl[2]), .bus_power_monitor_on_i(ctl[1]),
      .consuming_bus_power_i(ctl[0]), .sink_disc_threshold_i(thr),
      .auto_discharge_en_i(aen), .auto_discharge_failed_clr_i(fclr),
      .discharge_en_o(dis), .auto_discharge_failed_o(fail));

   task automatic report_and_stop();
      if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   // read and compare in one call
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      pm.rd(a, d);
      chk(d, e);
   endtask

   // bounded wait for discharge output to reach v; n counts cycles waited
   task automatic wait_dis(input logic v, input int lim);
      n = 0;
      while (dis !== v && n < lim) begin
         @(posedge core_clk_i);
         #1;
         n++;
      end
   endtask

   // bus power up above 4 V, then down below 3.5 V; comparators need sync time
   task automatic vbus_up_down();
      a4 = 1'b1;
      repeat (8) @(posedge core_clk_i);
      #1;
      a4 = 1'b0;
      b35 = 1'b1;
   endtask

   // wait k rising edges, then step off the edge like every other drive
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk_i);
      #1;
   endtask

   initial begin
      #20000;
      n_mismatch++;
      report_and_stop();
   end

   initial begin
      repeat (16) @(posedge core_clk_i);
      #1;
      sys_rst_i = 1'b0;
      rdc(8'h1E, 8'h00);
      rdc(8'h1D, 8'h00);
      // each control level alone shows in its own bit, bit 6 stays zero
      for (int i = 0; i < 5; i++) begin
         ctl = 5'h10 >> i;
         cyc(2);
         rdc(8'h1E, bitv[i]);
      end
      // stand-in for the polling period before trusting the detected bit
      ctl = 5'h02;
      cyc(100);
      a4 = 1'b1;
      cyc(8);
      rdc(8'h1E, 8'h0C);
      rdc(8'h1D, 8'h00);
      pm.wr(8'h1E, 8'hFF);
      rdc(8'h1E, 8'h0C);
      a4 = 1'b0;
      cyc(8);
      rdc(8'h1E, 8'h0C);
      c1 = 1'b1;
      cyc(8);
      rdc(8'h1E, 8'h0E);
      c1 = 1'b0;
      c2 = 1'b1;
      cyc(8);
      rdc(8'h1E, 8'h0E);
      c2 = 1'b0;
      // detected falls with zero threshold: discharge, then time out
      aen = 1'b1;
      b35 = 1'b1;
      wait_dis(1'b1, 12);
      chk({7'h00, dis}, 8'h01);
      rdc(8'h1E, 8'h08);
      wait_dis(1'b0, 40);
      chk({7'h00, fail}, 8'h01);
      chk({7'h00, n > 14 && n < 21}, 8'h01);
      fclr = 1'b1;
      cyc(2);
      fclr = 1'b0;
      chk({7'h00, fail}, 8'h00);
      // reaching safe zero ends discharge without a failure
      b35 = 1'b0;
      vbus_up_down();
      wait_dis(1'b1, 12);
      s0 = 1'b1;
      wait_dis(1'b0, 8);
      chk({6'h00, dis, fail}, 8'h00);
      // nonzero threshold: a fall brings no discharge
      s0 = 1'b0;
      b35 = 1'b0;
      thr = 10'h001;
      vbus_up_down();
      wait_dis(1'b1, 12);
      chk({7'h00, dis}, 8'h00);
      // monitor switched off forces the detected bit low
      b35 = 1'b0;
      a4 = 1'b1;
      cyc(8);
      rdc(8'h1E, 8'h0C);
      ctl = 5'h00;
      cyc(2);
      rdc(8'h1E, 8'h00);
      report_and_stop();
   end
endmodule
